/* shared/eag_pkg.sv */
package eag_pkg;

  // ----------------------------------------------------------------
  // widths and field positions
  // ----------------------------------------------------------------
  localparam int unsigned EAG_WORD_W    = 16;
  localparam int unsigned EAG_ADDR_W    = 32;
  localparam int unsigned EAG_NREGS     = 16;
  localparam int unsigned EAG_MODE_LSB  = 3;
  localparam int unsigned EAG_REG_LSB   = 0;
  localparam int unsigned EAG_XT_DA_BIT = 15;
  localparam int unsigned EAG_XT_RN_LSB = 12;
  localparam int unsigned EAG_MAX_LEN   = 5;

  // ----------------------------------------------------------------
  // mode and special sub-mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] EAG_M_DREG  = 3'h0;
  localparam logic [2:0] EAG_M_AREG  = 3'h1;
  localparam logic [2:0] EAG_M_AIND  = 3'h2;
  localparam logic [2:0] EAG_M_APOST = 3'h3;
  localparam logic [2:0] EAG_M_APRE  = 3'h4;
  localparam logic [2:0] EAG_M_ADISP = 3'h5;
  localparam logic [2:0] EAG_M_AIDX  = 3'h6;
  localparam logic [2:0] EAG_M_SPEC  = 3'h7;
  localparam logic [2:0] EAG_S_ABSW  = 3'h0;
  localparam logic [2:0] EAG_S_ABSL  = 3'h1;
  localparam logic [2:0] EAG_S_PCD   = 3'h2;
  localparam logic [2:0] EAG_S_PCX   = 3'h3;
  localparam logic [2:0] EAG_S_IMM   = 3'h4;
  localparam logic [2:0] EAG_SP_NUM  = 3'h7;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EAG_SZ_BYTE = 2'h0,
    EAG_SZ_WORD = 2'h1,
    EAG_SZ_LONG = 2'h2
  } eag_size_t;

  typedef enum logic [5:0] {
    EAG_IDLE  = 6'h01,
    EAG_OPEXT = 6'h02,
    EAG_EXT   = 6'h04,
    EAG_IDX   = 6'h08,
    EAG_CALC  = 6'h10,
    EAG_DONE  = 6'h20
  } eag_state_t;

  typedef struct packed {
    logic [15:0] opword;
    eag_size_t   size;
    logic        is_jump;
    logic        is_write;
    logic        sr_op;
    logic [1:0]  op_ext;
    logic [31:0] pc;
  } eag_req_t;

  typedef struct packed {
    logic [31:0] ea;
    logic [31:0] operand;
    logic [31:0] op_imm;
    logic [2:0]  len;
    logic        mem;
    logic        prog;
    logic        sr_dest;
    logic        illegal;
    logic [3:0]  bcd_msd;
    logic [3:0]  bcd_lsd;
  } eag_result_t;

  typedef struct packed {
    logic        we;
    logic [3:0]  addr;
    logic [31:0] data;
  } eag_rfw_t;

  typedef struct packed {
    eag_state_t  fsm;
    eag_req_t    req;
    logic [31:0] base;
    logic [31:0] idx;
    logic [31:0] ext;
    logic [31:0] opimm;
    logic [31:0] pcx;
    logic [1:0]  cnt;
    logic        base_cap;
    eag_result_t res;
    eag_rfw_t    rfw;
  } eag_st_t;

  localparam eag_st_t EAG_ST_RST = '{fsm: EAG_IDLE, default: '0};

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] eag_sext16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction : eag_sext16

  function automatic logic [31:0] eag_sext8(input logic [7:0] v);
    return {{24{v[7]}}, v};
  endfunction : eag_sext8

  function automatic logic [31:0] eag_step(input eag_size_t sz, input logic [2:0] rn);
    case (sz)
      EAG_SZ_BYTE: return (rn == EAG_SP_NUM) ? 32'h2 : 32'h1;
      EAG_SZ_WORD: return 32'h2;
      default:     return 32'h4;
    endcase
  endfunction : eag_step

  function automatic logic [31:0] eag_imm(input eag_size_t sz, input logic [31:0] w);
    case (sz)
      EAG_SZ_BYTE: return {24'h0, w[7:0]};
      EAG_SZ_WORD: return {16'h0, w[15:0]};
      default:     return w;
    endcase
  endfunction : eag_imm

  function automatic logic [1:0] eag_ext_words(input logic [15:0] ow, input eag_size_t sz,
                                               input logic sr_op);
    logic [2:0] md;
    logic [2:0] rn;
    md = ow[EAG_MODE_LSB +: 3];
    rn = ow[EAG_REG_LSB +: 3];
    if (md == EAG_M_ADISP || md == EAG_M_AIDX) return 2'h1;
    if (md != EAG_M_SPEC) return 2'h0;
    case (rn)
      EAG_S_ABSW, EAG_S_PCD, EAG_S_PCX: return 2'h1;
      EAG_S_ABSL:                       return 2'h2;
      EAG_S_IMM: return sr_op ? 2'h0 : ((sz == EAG_SZ_LONG) ? 2'h2 : 2'h1);
      default:                          return 2'h0;
    endcase
  endfunction : eag_ext_words

  function automatic logic [3:0] eag_base_idx(input logic [15:0] ow);
    return {ow[EAG_MODE_LSB +: 3] != EAG_M_DREG, ow[EAG_REG_LSB +: 3]};
  endfunction : eag_base_idx

endpackage : eag_pkg

/* hw/eag_regfile.sv */
module eag_regfile
  import eag_pkg::*;
#(
  parameter int unsigned DEPTH = EAG_NREGS,
  parameter int unsigned W     = EAG_ADDR_W
) (
  // clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     arst_n_i,
  // write port
  input  wire logic                     we_i,
  input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input  wire logic [W-1:0]             wdata_i,
  // read port, data one cycle later
  input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic      [W-1:0]             rdata_o
);

  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] rdata_r;

  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= mem_r[raddr_i];
    end
  end

  assign rdata_o = rdata_r;

endmodule : eag_regfile

/* hw/eag_decoder.sv */
module eag_decoder
  import eag_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  // instruction request
  input  wire logic        req_valid_i,
  input  wire eag_req_t    req_i,
  output logic             req_ready_o,
  // extension word stream
  input  wire logic        ext_valid_i,
  input  wire logic [15:0] ext_word_i,
  output logic             ext_ready_o,
  // decoded operand
  output logic             res_valid_o,
  input  wire logic        res_ready_i,
  output eag_result_t      res_o,
  // register load port
  input  wire logic        reg_wr_i,
  input  wire logic [3:0]  reg_wr_addr_i,
  input  wire logic [31:0] reg_wr_data_i,
  output logic             reg_wr_ready_o
);

  eag_st_t     st_r;
  eag_st_t     st_nxt;
  logic [3:0]  rd_addr;
  logic [31:0] rf_rdata;
  logic        rf_we;
  logic [3:0]  rf_waddr;
  logic [31:0] rf_wdata;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  assign reg_wr_ready_o = !st_r.rfw.we;
  assign rf_we          = st_r.rfw.we | reg_wr_i;
  assign rf_waddr       = st_r.rfw.we ? st_r.rfw.addr : reg_wr_addr_i;
  assign rf_wdata       = st_r.rfw.we ? st_r.rfw.data : reg_wr_data_i;

  eag_regfile #(
    .DEPTH (EAG_NREGS),
    .W     (EAG_ADDR_W)
  ) u_regs (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .we_i      (rf_we),
    .waddr_i   (rf_waddr),
    .wdata_i   (rf_wdata),
    .raddr_i   (rd_addr),
    .rdata_o   (rf_rdata)
  );

  // ----------------------------------------------------------------
  // decode fields
  // ----------------------------------------------------------------
  logic [2:0]  mode;
  logic [2:0]  rnum;
  logic [1:0]  ewords;
  logic [1:0]  ewords_in;
  logic [31:0] base_v;
  logic [31:0] step;
  logic        idx_mode;

  assign mode      = st_r.req.opword[EAG_MODE_LSB +: 3];
  assign rnum      = st_r.req.opword[EAG_REG_LSB +: 3];
  assign ewords    = eag_ext_words(st_r.req.opword, st_r.req.size, st_r.req.sr_op);
  assign ewords_in = eag_ext_words(req_i.opword, req_i.size, req_i.sr_op);
  assign base_v    = st_r.base_cap ? rf_rdata : st_r.base;
  assign step      = eag_step(st_r.req.size, rnum);
  assign idx_mode  = (mode == EAG_M_AIDX) || (mode == EAG_M_SPEC && rnum == EAG_S_PCX);

  assign req_ready_o = (st_r.fsm == EAG_IDLE);
  assign ext_ready_o = (st_r.fsm == EAG_OPEXT) || (st_r.fsm == EAG_EXT);
  assign res_valid_o = (st_r.fsm == EAG_DONE);
  assign res_o       = st_r.res;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    eag_result_t r;
    r              = '0;
    st_nxt         = st_r;
    st_nxt.rfw.we  = 1'b0;
    st_nxt.base_cap = 1'b0;
    rd_addr        = eag_base_idx(req_i.opword);
    if (st_r.base_cap) begin
      st_nxt.base = rf_rdata;
    end
    case (st_r.fsm)
      EAG_IDLE: begin
        if (req_valid_i) begin
          st_nxt.req      = req_i;
          st_nxt.base_cap = 1'b1;
          st_nxt.ext      = '0;
          st_nxt.opimm    = '0;
          st_nxt.idx      = '0;
          // extension words begin after the op word and its own immediates
          st_nxt.pcx = req_i.pc + {29'h0, req_i.op_ext, 1'b0} + 32'h2;
          if (req_i.op_ext != 2'h0) begin
            st_nxt.cnt = req_i.op_ext;
            st_nxt.fsm = EAG_OPEXT;
          end else if (ewords_in != 2'h0) begin
            st_nxt.cnt = ewords_in;
            st_nxt.fsm = EAG_EXT;
          end else begin
            st_nxt.fsm = EAG_CALC;
          end
        end
      end
      EAG_OPEXT: begin
        if (ext_valid_i) begin
          st_nxt.opimm = {st_r.opimm[15:0], ext_word_i};
          st_nxt.cnt   = st_r.cnt - 2'h1;
          if (st_r.cnt == 2'h1) begin
            st_nxt.cnt = ewords;
            st_nxt.fsm = (ewords != 2'h0) ? EAG_EXT : EAG_CALC;
          end
        end
      end
      EAG_EXT: begin
        rd_addr = {ext_word_i[EAG_XT_DA_BIT], ext_word_i[EAG_XT_RN_LSB +: 3]};
        if (ext_valid_i) begin
          st_nxt.ext = {st_r.ext[15:0], ext_word_i};
          st_nxt.cnt = st_r.cnt - 2'h1;
          if (st_r.cnt == 2'h1) begin
            st_nxt.fsm = idx_mode ? EAG_IDX : EAG_CALC;
          end
        end
      end
      EAG_IDX: begin
        st_nxt.idx = rf_rdata;
        st_nxt.fsm = EAG_CALC;
      end
      EAG_CALC: begin
        r.len    = 3'({1'b0, st_r.req.op_ext} + {1'b0, ewords} + 3'h1);
        r.op_imm = eag_imm(st_r.req.size, st_r.opimm);
        case (mode)
          EAG_M_DREG, EAG_M_AREG: begin
            r.operand = base_v;
          end
          EAG_M_AIND: begin
            r.ea   = base_v;
            r.mem  = 1'b1;
            r.prog = st_r.req.is_jump;
          end
          EAG_M_APOST: begin
            r.ea              = base_v;
            r.mem             = 1'b1;
            st_nxt.rfw.we     = 1'b1;
            st_nxt.rfw.addr   = {1'b1, rnum};
            st_nxt.rfw.data   = base_v + step;
          end
          EAG_M_APRE: begin
            r.ea              = base_v - step;
            r.mem             = 1'b1;
            st_nxt.rfw.we     = 1'b1;
            st_nxt.rfw.addr   = {1'b1, rnum};
            st_nxt.rfw.data   = base_v - step;
          end
          EAG_M_ADISP: begin
            r.ea   = base_v + eag_sext16(st_r.ext[15:0]);
            r.mem  = 1'b1;
            r.prog = st_r.req.is_jump;
          end
          EAG_M_AIDX: begin
            r.ea   = base_v + eag_sext8(st_r.ext[7:0]) + st_r.idx;
            r.mem  = 1'b1;
            r.prog = st_r.req.is_jump;
          end
          default: begin
            case (rnum)
              EAG_S_ABSW: begin
                r.ea   = eag_sext16(st_r.ext[15:0]);
                r.mem  = 1'b1;
                r.prog = st_r.req.is_jump;
              end
              EAG_S_ABSL: begin
                r.ea   = st_r.ext;
                r.mem  = 1'b1;
                r.prog = st_r.req.is_jump;
              end
              EAG_S_PCD: begin
                r.ea   = st_r.pcx + eag_sext16(st_r.ext[15:0]);
                r.mem  = 1'b1;
                r.prog = 1'b1;
              end
              EAG_S_PCX: begin
                r.ea   = st_r.pcx + eag_sext8(st_r.ext[7:0]) + st_r.idx;
                r.mem  = 1'b1;
                r.prog = 1'b1;
              end
              EAG_S_IMM: begin
                if (st_r.req.sr_op) begin
                  r.sr_dest = 1'b1;
                end else begin
                  r.operand = eag_imm(st_r.req.size, st_r.ext);
                end
              end
              default: begin
                r.illegal = 1'b1;
              end
            endcase
          end
        endcase
        // writes never go to program space
        r.prog        = r.prog & !st_r.req.is_write;
        r.bcd_msd     = r.operand[7:4];
        r.bcd_lsd     = r.operand[3:0];
        st_nxt.res    = r;
        st_nxt.fsm    = EAG_DONE;
      end
      EAG_DONE: begin
        if (res_ready_i) begin
          st_nxt.fsm = EAG_IDLE;
        end
      end
      default: begin
        st_nxt = EAG_ST_RST;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= EAG_ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_bare_accept;
    req_valid_i && req_ready_o && req_i.op_ext == 2'h0 && ewords_in == 2'h0;
  endsequence

  sequence s_answer;
    !res_valid_o ##1 !res_valid_o ##1 res_valid_o;
  endsequence

  property p_len_range;
    res_valid_o |-> (res_o.len >= 3'h1 && res_o.len <= 3'(EAG_MAX_LEN));
  endproperty
  a_len_range: assert property (p_len_range) else $error("length out of range");

  property p_bare_answer;
    s_bare_accept |-> s_answer;
  endproperty
  a_bare_answer: assert property (p_bare_answer) else $error("bare request late");

  property p_write_data;
    res_valid_o && st_r.req.is_write |-> !res_o.prog;
  endproperty
  a_write_data: assert property (p_write_data) else $error("write tagged program");

  property p_direct_nomem;
    res_valid_o && (mode == EAG_M_DREG || mode == EAG_M_AREG)
      |-> !res_o.mem && res_o.operand == st_r.base;
  endproperty
  a_direct_nomem: assert property (p_direct_nomem) else $error("direct mode bad");

  property p_sp_byte_inc;
    st_r.fsm == EAG_CALC && mode == EAG_M_APOST && rnum == EAG_SP_NUM &&
      st_r.req.size == EAG_SZ_BYTE
      |=> st_r.rfw.we && st_r.rfw.data == st_r.res.ea + 32'h2;
  endproperty
  a_sp_byte_inc: assert property (p_sp_byte_inc) else $error("stack byte step");

  property p_predec;
    st_r.fsm == EAG_CALC && mode == EAG_M_APRE
      |=> res_o.ea == st_r.rfw.data && st_r.rfw.we ##1 !st_r.rfw.we;
  endproperty
  a_predec: assert property (p_predec) else $error("predecrement update");

  property p_pc_disp;
    res_valid_o && mode == EAG_M_SPEC && rnum == EAG_S_PCD && !st_r.req.is_write
      |-> res_o.prog && res_o.ea == st_r.pcx + eag_sext16(st_r.ext[15:0]);
  endproperty
  a_pc_disp: assert property (p_pc_disp) else $error("counter displacement");

  property p_abs_long;
    res_valid_o && mode == EAG_M_SPEC && rnum == EAG_S_ABSL |-> res_o.ea == st_r.ext;
  endproperty
  a_abs_long: assert property (p_abs_long) else $error("absolute long address");

  property p_illegal;
    res_valid_o && res_o.illegal |-> !res_o.mem && !st_r.rfw.we && res_o.len == 3'(
      {1'b0, st_r.req.op_ext} + 3'h1);
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal issued access");

  property p_hold;
    res_valid_o && !res_ready_i |=> res_valid_o && $stable(res_o);
  endproperty
  a_hold: assert property (p_hold) else $error("result not held");

endmodule : eag_decoder

/* verif/eag_fetch_model.sv */
module eag_fetch_model
  import eag_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  // extension word stream
  input  wire logic        ext_ready_i,
  output logic             ext_valid_o,
  output logic [15:0]      ext_word_o,
  // result side
  output logic             res_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] words_q[$];
  int          seed;

  initial begin
    seed        = 32'h474C;
    ext_valid_o = 1'b0;
    ext_word_o  = 16'h0000;
    res_ready_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // fetch side
  // ----------------------------------------------------------------
  // a word stands until taken; in a gap the word lines invert every cycle
  always @(posedge ref_clk_i) begin
    if (!arst_n_i) begin
      ext_valid_o <= 1'b0;
    end else if (!ext_valid_o || ext_ready_i) begin
      if (ext_valid_o) begin
        void'(words_q.pop_front());
      end
      if (words_q.size() > 0 && ($random(seed) % 3) != 0) begin
        ext_valid_o <= 1'b1;
        ext_word_o  <= words_q[0];
      end else begin
        ext_valid_o <= 1'b0;
        ext_word_o  <= ~ext_word_o;
      end
    end
    res_ready_o <= ($random(seed) % 4) != 0;
  end

endmodule : eag_fetch_model

/* verif/effective_address_generator_bench.sv */
module effective_address_generator_bench;
  import eag_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        ref_clk_i;
  logic        arst_n_i;
  logic        req_valid_i;
  eag_req_t    req_i;
  logic        req_ready_o;
  logic        ext_valid_i;
  logic [15:0] ext_word_i;
  logic        ext_ready_o;
  logic        res_valid_o;
  logic        res_ready_i;
  eag_result_t res_o;
  logic        reg_wr_i;
  logic [3:0]  reg_wr_addr_i;
  logic [31:0] reg_wr_data_i;
  logic        reg_wr_ready_o;
  logic [31:0] rf[16];
  int          seed;
  int          num_errors;
  int          samples_checked;

  eag_decoder DUT (
    .ref_clk_i      (ref_clk_i),
    .arst_n_i       (arst_n_i),
    .req_valid_i    (req_valid_i),
    .req_i          (req_i),
    .req_ready_o    (req_ready_o),
    .ext_valid_i    (ext_valid_i),
    .ext_word_i     (ext_word_i),
    .ext_ready_o    (ext_ready_o),
    .res_valid_o    (res_valid_o),
    .res_ready_i    (res_ready_i),
    .res_o          (res_o),
    .reg_wr_i       (reg_wr_i),
    .reg_wr_addr_i  (reg_wr_addr_i),
    .reg_wr_data_i  (reg_wr_data_i),
    .reg_wr_ready_o (reg_wr_ready_o)
  );

  eag_fetch_model u_fetch (
    .ref_clk_i   (ref_clk_i),
    .arst_n_i    (arst_n_i),
    .ext_ready_i (ext_ready_o),
    .ext_valid_o (ext_valid_i),
    .ext_word_o  (ext_word_i),
    .res_ready_o (res_ready_i)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic load_reg(input logic [3:0] n, input logic [31:0] v);
    int k;
    reg_wr_i      <= 1'b1;
    reg_wr_addr_i <= n;
    reg_wr_data_i <= v;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (reg_wr_ready_o !== 1'b1 && k < 50);
    if (k >= 50) num_errors++;
    reg_wr_i <= 1'b0;
    rf[n] = v;
    @(posedge ref_clk_i);
  endtask : load_reg

  // one instruction: reference result worked out, then compared
  task automatic run(input int md, input int rn, input int sz);
    eag_req_t    q;
    logic [15:0] w[4];
    logic [15:0] e0;
    logic [15:0] e1;
    logic [31:0] ea;
    logic [31:0] opnd;
    logic [31:0] opi;
    logic [31:0] ix;
    logic [31:0] stp;
    logic        prog;
    logic        ill;
    logic        imm;
    int          nop;
    int          nea;
    int          k;
    int          ai;
    for (k = 0; k < 4; k++) w[k] = 16'($random(seed));
    q.opword = {10'($random(seed)), 3'(md), 3'(rn)};
    q.size     = eag_size_t'(sz);
    q.is_jump  = 1'($random(seed));
    q.is_write = 1'($random(seed));
    imm        = (md == 7 && rn == 4);
    q.sr_op    = imm ? 1'($random(seed)) : 1'b0;
    nop        = (($random(seed) & 1) != 0) ? ((sz == 2) ? 2 : 1) : 0;
    q.op_ext   = 2'(nop);
    q.pc       = 32'($random(seed)) & 32'hFFFF_FFFE;
    opi  = (sz == 0) ? {24'h0, w[0][7:0]} : (sz == 1) ? {16'h0, w[0]} : {w[0], w[1]};
    e0   = w[nop];
    e1   = w[nop + 1];
    ai   = 8 + rn;
    ix   = rf[{e0[15], e0[14:12]}];
    stp  = (sz == 0) ? ((rn == 7) ? 32'h2 : 32'h1) : (sz == 1) ? 32'h2 : 32'h4;
    prog = q.is_jump & ~q.is_write;
    ill  = 1'b0;
    nea  = 0;
    ea   = 32'h0;
    opnd = 32'h0;
    case (md)
      0: opnd = rf[rn];
      1: opnd = rf[ai];
      2: ea = rf[ai];
      3: begin
        ea     = rf[ai];
        rf[ai] = ea + stp;
        prog   = 1'b0;
      end
      4: begin
        rf[ai] = rf[ai] - stp;
        ea     = rf[ai];
        prog   = 1'b0;
      end
      5: ea = rf[ai] + {{16{e0[15]}}, e0};
      6: ea = rf[ai] + {{24{e0[7]}}, e0[7:0]} + ix;
      default: begin
        case (rn)
          0: ea = {{16{e0[15]}}, e0};
          1: ea = {e0, e1};
          2: ea = q.pc + 32'(2 + 2 * nop) + {{16{e0[15]}}, e0};
          3: ea = q.pc + 32'(2 + 2 * nop) + {{24{e0[7]}}, e0[7:0]} + ix;
          4: opnd = (sz == 0) ? {24'h0, e0[7:0]} : (sz == 1) ? {16'h0, e0} : {e0, e1};
          default: ill = 1'b1;
        endcase
        if (rn == 2 || rn == 3) prog = ~q.is_write;
      end
    endcase
    if (md == 5 || md == 6 || (md == 7 && rn < 4 && rn != 1)) nea = 1;
    if (md == 7 && rn == 1) nea = 2;
    if (imm && !q.sr_op) nea = (sz == 2) ? 2 : 1;
    for (k = 0; k < nop + nea; k++) u_fetch.words_q.push_back(w[k]);
    req_i       <= q;
    req_valid_i <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (req_ready_o !== 1'b1 && k < 50);
    if (k >= 50) num_errors++;
    req_valid_i <= 1'b0;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (!(res_valid_o === 1'b1 && res_ready_i === 1'b1) && k < 200);
    if (k >= 200) num_errors++;
    check(res_o.len, 32'(1 + nop + nea));
    check(res_o.illegal, ill);
    if (nop > 0) check(res_o.op_imm, opi);
    if ((md >= 2 && md <= 6) || (md == 7 && rn < 4)) begin
      check(res_o.ea, ea);
      check(res_o.mem, 1'b1);
      check(res_o.prog, prog);
    end
    if (md < 2 || ill) check(res_o.mem, 1'b0);
    if (md < 2 || (imm && !q.sr_op)) check(res_o.operand, opnd);
    if (imm) check(res_o.sr_dest, q.sr_op);
    if (imm && !q.sr_op) check({res_o.bcd_msd, res_o.bcd_lsd}, opnd[7:0]);
  endtask : run

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    seed            = 32'h474C;
    num_errors      = 0;
    samples_checked = 0;
    arst_n_i        = 1'b0;
    req_valid_i     = 1'b0;
    req_i           = '0;
    reg_wr_i        = 1'b0;
    reg_wr_addr_i   = 4'h0;
    reg_wr_data_i   = 32'h0;
    repeat (4) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 16; i++) load_reg(4'(i), 32'($random(seed)));
    $display("test reset_and_load done");
    // every mode, register or sub-mode, and size, twice with fresh values
    for (int p = 0; p < 2; p++) begin
      for (int md = 0; md < 8; md++) begin
        for (int rn = 0; rn < 8; rn++) begin
          for (int sz = 0; sz < 3; sz++) begin
            load_reg(4'($random(seed)), 32'($random(seed)));
            run(md, rn, sz);
          end
        end
      end
    end
    $display("test mode_sweep done");
    final_report();
  end

  initial begin
    #(80000 * 40);
    num_errors++;
    final_report();
  end

endmodule : effective_address_generator_bench
